// ---- src/vmx_mixer_ctrl.sv ----
// Purpose: Mixer, output and converter control registers and the pixel path they steer.
// Assumes: All inputs, pins included, are synchronous to clk; register port is synchronous.
// Notes: Pixel layout is [23:16] green/Y, [15:8] blue/Cb, [7:0] red/Cr.
// Functional notes
// - Mixer control bit 7 low means luma/chroma input, high means green/blue/red.
// - Bits 6-5 pick converter data: A, B, mixed; code 3 reserved.
// - Bits 4-2 route A, B or fill colour onto mixer inputs V1 and V2.
// - Crosspoint code all ones takes routing from the three crosspoint pins.
// - Bits 1-0 pick blend, add or scale mixer equation; code 3 reserved.
// - Three fill registers give the constant fill colour source.
// - Key delay output lags key input 14 cycles, or 12 when short.
// - Key table off passes 9-bit alpha; on, alpha 7-0 address the table.
// - Bypass mode passes A or B unmodified while strobe low; otherwise mixing while strobe high.
// - In bypass with strobe low, source B bit picks port B over A.
// - Output drive bit enables the 24-bit output, else high impedance.
// - Chroma MSB invert bit flips output bits 15 and 7.
// - Output 422 bit selects 16-bit 4:2:2 instead of 24-bit output.
// - Converter sync and blank lag 15 clocks, or 2 when short.
// - Converter chroma offset bit flips the chroma MSBs toward the converters.
// - Converter power bit runs the converters; low powers them down.
// - Converter setup bit selects 7.5 IRE blanking instead of 0 IRE.
// - Converter matrix bit converts luma/chroma to green/blue/red.
`timescale 1ns/1ps
`default_nettype none
`include "vmx_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module vmx_mixer_ctrl #(
  parameter int KEY_LAT_LONG = `VMX_KEY_LAT_LONG,
  parameter int KEY_LAT_SHORT = `VMX_KEY_LAT_SHORT,
  parameter int SYNC_LAT_LONG = `VMX_SYNC_LAT_LONG,
  parameter int SYNC_LAT_SHORT = `VMX_SYNC_LAT_SHORT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pixel inputs.
  input wire logic [23:0] first_pixel_port,
  input wire logic [23:0] second_pixel_port,
  input wire logic pixel_valid,
  output logic pixel_ready,
  input wire logic [8:0] alpha_in,
  input wire logic [2:0] crosspoint_select,
  input wire logic bypass_strobe_n,
  // Key table loading.
  input wire logic key_table_wr,
  input wire logic [7:0] key_table_addr,
  input wire logic [7:0] key_table_data,
  // Key delay line.
  input wire logic key_delay_in,
  output logic key_delay_output,
  // Digital output.
  output logic [23:0] mix_out_data,
  output logic mix_out_oe,
  output logic mix_out_valid,
  input wire logic mix_out_ready,
  // Converter side.
  input wire logic conv_sync_in,
  input wire logic conv_blank_in,
  output logic [23:0] conv_data,
  output logic conv_sync,
  output logic conv_blank,
  output logic converter_power_on,
  output logic conv_setup
);
  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel mixer arithmetic; alpha above unity is clamped to unity.
  function automatic logic [7:0] vmx_mix(input logic [7:0] v1, input logic [7:0] v2,
                                         input logic [8:0] a, input logic [1:0] fn);
    logic [8:0] ac;
    logic [17:0] p1;
    logic [17:0] t;
    logic [8:0] s;
    logic [7:0] r;
    ac = a[8] ? `VMX_ALPHA_UNITY : a;
    p1 = 18'(v1 * ac);
    t = p1 + 18'(v2 * 9'(`VMX_ALPHA_UNITY - ac));
    s = 9'(p1 >> 8) + {1'b0, v2};
    case (fn)
      2'h1: r = s[8] ? 8'hFF : s[7:0];
      2'h2: r = p1[15:8];
      default: r = t[15:8];
    endcase
    return r;
  endfunction

  // Flips both chroma MSBs, bits 15 and 7.
  function automatic logic [23:0] vmx_cflip(input logic [23:0] p, input logic en);
    return p ^ {8'h00, en, 7'h00, en, 7'h00};
  endfunction

  function automatic logic [7:0] vmx_clamp(input logic signed [19:0] x);
    return (x < 0) ? 8'h00 : ((x > 255) ? 8'hFF : x[7:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0] mixer_control_r;
  logic [7:0] fill_red_r;
  logic [7:0] fill_green_r;
  logic [7:0] fill_blue_r;
  logic [7:0] output_control_r;
  logic [7:0] converter_control_r;
  logic [7:0] rd_mux;
  logic [3:0] cfg_quiet_r;
  wire reg_write = reg_cs & reg_wr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mixer_control_r <= `VMX_RST_REG;
      fill_red_r <= `VMX_RST_REG;
      fill_green_r <= `VMX_RST_REG;
      fill_blue_r <= `VMX_RST_REG;
      output_control_r <= `VMX_RST_REG;
      converter_control_r <= `VMX_RST_REG;
    end else if (reg_write) begin
      if (reg_addr == `VMX_ADDR_MIXER) mixer_control_r <= reg_wdata;
      if (reg_addr == `VMX_ADDR_FILL_RED) fill_red_r <= reg_wdata;
      if (reg_addr == `VMX_ADDR_FILL_GREEN) fill_green_r <= reg_wdata;
      if (reg_addr == `VMX_ADDR_FILL_BLUE) fill_blue_r <= reg_wdata;
      // Reserved bits are kept at zero so they read back as zero.
      if (reg_addr == `VMX_ADDR_OUTPUT) output_control_r <= reg_wdata & `VMX_MASK_OUTPUT;
      if (reg_addr == `VMX_ADDR_CONVERTER) begin
        converter_control_r <= reg_wdata & `VMX_MASK_CONVERTER;
      end
    end
  end

  assign rd_mux = (reg_addr == `VMX_ADDR_MIXER) ? mixer_control_r :
                  (reg_addr == `VMX_ADDR_FILL_RED) ? fill_red_r :
                  (reg_addr == `VMX_ADDR_FILL_GREEN) ? fill_green_r :
                  (reg_addr == `VMX_ADDR_FILL_BLUE) ? fill_blue_r :
                  (reg_addr == `VMX_ADDR_OUTPUT) ? output_control_r :
                  (reg_addr == `VMX_ADDR_CONVERTER) ? converter_control_r : 8'h00;

  // Cycles since the last register write, saturating; checks settle on it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      cfg_quiet_r <= 4'h0;
    end else begin
      if (reg_cs && !reg_wr) reg_rdata <= rd_mux;
      cfg_quiet_r <= reg_write ? 4'h0 : ((cfg_quiet_r == 4'hF) ? 4'hF : 4'(cfg_quiet_r + 4'h1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode.
  wire blend_color_space = mixer_control_r[`VMX_MIX_CSPACE];
  wire [1:0] converter_source = mixer_control_r[`VMX_MIX_CSRC_HI:`VMX_MIX_CSRC_LO];
  wire [2:0] xp_field = mixer_control_r[`VMX_MIX_XP_HI:`VMX_MIX_XP_LO];
  wire [1:0] blend_function = mixer_control_r[`VMX_MIX_FN_HI:`VMX_MIX_FN_LO];
  wire key_latency_short = output_control_r[`VMX_OUT_KEY_SHORT];
  wire key_table_enable = output_control_r[`VMX_OUT_TABLE_EN];
  wire bypass_mode = output_control_r[`VMX_OUT_BYPASS];
  wire bypass_source_b = output_control_r[`VMX_OUT_BYPASS_B];
  wire output_drive_enable = output_control_r[`VMX_OUT_DRIVE];
  wire output_chroma_msb_invert = output_control_r[`VMX_OUT_MSB_INV];
  wire output_422_select = output_control_r[`VMX_OUT_422];
  wire converter_sync_delay = converter_control_r[`VMX_CONV_SYNC_SHORT];
  wire converter_chroma_offset = converter_control_r[`VMX_CONV_CHROMA_OFS];
  wire converter_power_bit = converter_control_r[`VMX_CONV_POWER];
  wire converter_setup_bit = converter_control_r[`VMX_CONV_SETUP];
  wire converter_color_matrix = converter_control_r[`VMX_CONV_MATRIX];

  ////////////////////////////////////////////////////////////////////////////////
  // Crosspoint and mixer.
  vmx_pkg::vmx_pix_type fill_pix;
  vmx_pkg::vmx_pix_type v1;
  vmx_pkg::vmx_pix_type v2;
  vmx_pkg::vmx_pix_type mixed_pix;
  vmx_pkg::vmx_pix_type mix_res;
  vmx_pkg::vmx_xp_type sel_eff;
  logic [7:0] key_table_r [256];
  logic [8:0] alpha_eff;

  assign fill_pix = {fill_green_r, fill_blue_r, fill_red_r};
  assign sel_eff = vmx_pkg::vmx_xp_type'((xp_field == 3'h7) ? crosspoint_select : xp_field);

  always_comb begin
    unique case (sel_eff)
      vmx_pkg::VMX_XP_AF: begin
        v1 = first_pixel_port;
        v2 = fill_pix;
      end
      vmx_pkg::VMX_XP_BA: begin
        v1 = second_pixel_port;
        v2 = first_pixel_port;
      end
      vmx_pkg::VMX_XP_BF: begin
        v1 = second_pixel_port;
        v2 = fill_pix;
      end
      vmx_pkg::VMX_XP_FA: begin
        v1 = fill_pix;
        v2 = first_pixel_port;
      end
      vmx_pkg::VMX_XP_FB: begin
        v1 = fill_pix;
        v2 = second_pixel_port;
      end
      // Reserved code, and the pins showing all ones, fall back to A/B.
      default: begin
        v1 = first_pixel_port;
        v2 = second_pixel_port;
      end
    endcase
  end

  // The table holds no reset; it is loaded before it is enabled.
  always_ff @(posedge clk) begin
    if (key_table_wr) key_table_r[key_table_addr] <= key_table_data;
  end
  assign alpha_eff = key_table_enable ? {1'b0, key_table_r[alpha_in[7:0]]} : alpha_in;

  // Two's-complement chroma is moved to offset binary around the arithmetic so
  // one unsigned datapath serves both colour spaces.
  wire chroma_signed = ~blend_color_space;
  wire [23:0] v1_u = vmx_cflip(v1, chroma_signed);
  wire [23:0] v2_u = vmx_cflip(v2, chroma_signed);
  wire [23:0] mix_u = {vmx_mix(v1_u[23:16], v2_u[23:16], alpha_eff, blend_function),
                       vmx_mix(v1_u[15:8], v2_u[15:8], alpha_eff, blend_function),
                       vmx_mix(v1_u[7:0], v2_u[7:0], alpha_eff, blend_function)};
  assign mixed_pix = vmx_cflip(mix_u, chroma_signed);

  // Outside bypass mode a low strobe holds the mixer off and V2 is passed.
  assign mix_res = (!bypass_strobe_n && bypass_mode) ?
                   (bypass_source_b ? second_pixel_port : first_pixel_port) :
                   (!bypass_strobe_n ? v2 : mixed_pix);

  ////////////////////////////////////////////////////////////////////////////////
  // Digital output formatting and buffer.
  logic phase_r;
  logic out_oe_r;
  wire accept = pixel_valid & pixel_ready;
  wire [23:0] fmt_pix = output_422_select ?
                        {8'h00, mix_res[23:16], (phase_r ? mix_res[7:0] : mix_res[15:8])} :
                        mix_res;
  wire [23:0] out_pix = vmx_cflip(fmt_pix, output_chroma_msb_invert);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
      out_oe_r <= 1'b0;
    end else begin
      if (accept) phase_r <= output_422_select ? ~phase_r : 1'b0;
      out_oe_r <= output_drive_enable;
    end
  end
  assign mix_out_oe = out_oe_r;

  vmx_skid #(
    .WIDTH(24)
  ) u_skid (
    .clk(clk),
    .rst(rst),
    .in_data(out_pix),
    .in_valid(pixel_valid),
    .in_ready(pixel_ready),
    .out_data(mix_out_data),
    .out_valid(mix_out_valid),
    .out_ready(mix_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Key and sync delay lines run every clock, independent of pixel stalls.
  logic [KEY_LAT_LONG-2:0] key_sh_r;
  logic [SYNC_LAT_LONG-2:0] sync_sh_r;
  logic [SYNC_LAT_LONG-2:0] blank_sh_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_sh_r <= '0;
      sync_sh_r <= '0;
      blank_sh_r <= '0;
      key_delay_output <= 1'b0;
      conv_sync <= 1'b0;
      conv_blank <= 1'b0;
    end else begin
      key_sh_r <= {key_sh_r[KEY_LAT_LONG-3:0], key_delay_in};
      sync_sh_r <= {sync_sh_r[SYNC_LAT_LONG-3:0], conv_sync_in};
      blank_sh_r <= {blank_sh_r[SYNC_LAT_LONG-3:0], conv_blank_in};
      key_delay_output <= key_latency_short ? key_sh_r[KEY_LAT_SHORT-2] :
                          key_sh_r[KEY_LAT_LONG-2];
      conv_sync <= converter_sync_delay ? sync_sh_r[SYNC_LAT_SHORT-2] :
                   sync_sh_r[SYNC_LAT_LONG-2];
      conv_blank <= converter_sync_delay ? blank_sh_r[SYNC_LAT_SHORT-2] :
                    blank_sh_r[SYNC_LAT_LONG-2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter data path.
  vmx_pkg::vmx_csrc_type csrc;
  assign csrc = vmx_pkg::vmx_csrc_type'(converter_source);
  // The reserved source code is treated as A pixels.
  wire [23:0] conv_src = (csrc == vmx_pkg::VMX_CS_B) ? second_pixel_port :
                         (csrc == vmx_pkg::VMX_CS_MIX) ? mix_res : first_pixel_port;
  wire [23:0] conv_ofs = vmx_cflip(conv_src, converter_chroma_offset);
  wire signed [19:0] mat_y = 20'(conv_ofs[23:16]);
  wire signed [19:0] mat_cb = 20'(10'({2'b00, conv_ofs[15:8]}) - `VMX_CHROMA_MID);
  wire signed [19:0] mat_cr = 20'(10'({2'b00, conv_ofs[7:0]}) - `VMX_CHROMA_MID);
  wire signed [19:0] mat_r = mat_y + ((`VMX_MAT_CR_R * mat_cr) >>> 8);
  wire signed [19:0] mat_g = mat_y - ((`VMX_MAT_CB_G * mat_cb + `VMX_MAT_CR_G * mat_cr) >>> 8);
  wire signed [19:0] mat_b = mat_y + ((`VMX_MAT_CB_B * mat_cb) >>> 8);
  wire [23:0] conv_mat = {vmx_clamp(mat_g), vmx_clamp(mat_b), vmx_clamp(mat_r)};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_data <= 24'h00_0000;
      converter_power_on <= 1'b0;
      conv_setup <= 1'b0;
    end else begin
      // Powered-down converters see quiet data to save switching.
      conv_data <= !converter_power_bit ? 24'h00_0000 :
                   (converter_color_matrix ? conv_mat : conv_ofs);
      converter_power_on <= converter_power_bit;
      conv_setup <= converter_setup_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (rst);

  property p_key_long;
    (cfg_quiet_r == 4'hF && !key_latency_short) |-> key_delay_output == $past(key_delay_in, 14);
  endproperty
  a_key_long: assert property (p_key_long) else $error("key delay not 14");

  property p_key_short;
    (cfg_quiet_r == 4'hF && key_latency_short) |-> key_delay_output == $past(key_delay_in, 12);
  endproperty
  a_key_short: assert property (p_key_short) else $error("key delay not 12");

  property p_sync_long;
    (cfg_quiet_r == 4'hF && !converter_sync_delay) |->
      conv_sync == $past(conv_sync_in, 15) && conv_blank == $past(conv_blank_in, 15);
  endproperty
  a_sync_long: assert property (p_sync_long) else $error("sync delay not 15");

  property p_sync_short;
    (cfg_quiet_r == 4'hF && converter_sync_delay) |-> conv_sync == $past(conv_sync_in, 2);
  endproperty
  a_sync_short: assert property (p_sync_short) else $error("sync delay not 2");

  property p_drive;
    reg_write && reg_addr == `VMX_ADDR_OUTPUT ##1 !reg_write |=> mix_out_oe == $past(reg_wdata[2], 2);
  endproperty
  a_drive: assert property (p_drive) else $error("output enable wrong");

  property p_power;
    (cfg_quiet_r >= 4'h2 && !converter_power_bit) |-> conv_data == 24'h00_0000 && !converter_power_on;
  endproperty
  a_power: assert property (p_power) else $error("converters not off");

  property p_ext_route;
    (xp_field == 3'h7 && crosspoint_select == 3'h4) |-> v1 == fill_pix && v2 == first_pixel_port;
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("pin routing wrong");

  property p_bypass;
    (bypass_mode && !bypass_strobe_n) |->
      mix_res == (bypass_source_b ? second_pixel_port : first_pixel_port);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass source wrong");

  property p_table_off;
    !key_table_enable |-> alpha_eff == alpha_in;
  endproperty
  a_table_off: assert property (p_table_off) else $error("alpha not direct");
endmodule
`default_nettype wire

// ---- src/vmx_defs.svh ----
// Purpose: Offsets, field positions, reset values and latencies of the mixer control block.
// Assumes: Included by the package and by the principal design file.
// Notes: Definitions only.
`ifndef VMX_DEFS_SVH
`define VMX_DEFS_SVH
`define VMX_ADDR_MIXER 4'h2
`define VMX_ADDR_FILL_RED 4'h3
`define VMX_ADDR_FILL_GREEN 4'h4
`define VMX_ADDR_FILL_BLUE 4'h5
`define VMX_ADDR_OUTPUT 4'h6
`define VMX_ADDR_CONVERTER 4'h7
`define VMX_RST_REG 8'h00
`define VMX_MASK_OUTPUT 8'hBF
`define VMX_MASK_CONVERTER 8'h3D
`define VMX_MIX_CSPACE 7
`define VMX_MIX_CSRC_HI 6
`define VMX_MIX_CSRC_LO 5
`define VMX_MIX_XP_HI 4
`define VMX_MIX_XP_LO 2
`define VMX_MIX_FN_HI 1
`define VMX_MIX_FN_LO 0
`define VMX_OUT_KEY_SHORT 7
`define VMX_OUT_TABLE_EN 5
`define VMX_OUT_BYPASS 4
`define VMX_OUT_BYPASS_B 3
`define VMX_OUT_DRIVE 2
`define VMX_OUT_MSB_INV 1
`define VMX_OUT_422 0
`define VMX_CONV_SYNC_SHORT 5
`define VMX_CONV_CHROMA_OFS 4
`define VMX_CONV_POWER 3
`define VMX_CONV_SETUP 2
`define VMX_CONV_MATRIX 0
`define VMX_KEY_LAT_LONG 14
`define VMX_KEY_LAT_SHORT 12
`define VMX_SYNC_LAT_LONG 15
`define VMX_SYNC_LAT_SHORT 2
`define VMX_MAT_CR_R 20'sh0_0167
`define VMX_MAT_CB_G 20'sh0_0058
`define VMX_MAT_CR_G 20'sh0_00B7
`define VMX_MAT_CB_B 20'sh0_01C6
`define VMX_CHROMA_MID 10'sh080
`define VMX_ALPHA_UNITY 9'h100
`endif

// ---- src/vmx_pkg.sv ----
// Purpose: Types shared by the mixer control block.
// Assumes: Constants live in vmx_defs.svh.
// Notes: Encodings match the register field codes.
`include "vmx_defs.svh"
package vmx_pkg;
  typedef logic [23:0] vmx_pix_type;
  typedef enum logic [1:0] {
    VMX_FN_BLEND = 2'h0,
    VMX_FN_ADD = 2'h1,
    VMX_FN_SCALE = 2'h2,
    VMX_FN_RSVD = 2'h3
  } vmx_fn_type;
  typedef enum logic [1:0] {
    VMX_CS_A = 2'h0,
    VMX_CS_B = 2'h1,
    VMX_CS_MIX = 2'h2,
    VMX_CS_RSVD = 2'h3
  } vmx_csrc_type;
  typedef enum logic [2:0] {
    VMX_XP_AB = 3'h0,
    VMX_XP_AF = 3'h1,
    VMX_XP_BA = 3'h2,
    VMX_XP_BF = 3'h3,
    VMX_XP_FA = 3'h4,
    VMX_XP_FB = 3'h5,
    VMX_XP_RSVD = 3'h6,
    VMX_XP_EXT = 3'h7
  } vmx_xp_type;
endpackage

// ---- src/vmx_skid.sv ----
// Purpose: Two-entry buffer between the mixer result and the digital output.
// Assumes: Both sides run on clk.
// Notes: Output data, valid and ready all come straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module vmx_skid #(
  parameter int WIDTH = 24
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side.
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] skid_r;
  logic skid_valid_r;
  logic skid_valid_nxt;
  wire accept = in_valid & in_ready;
  wire head_free = ~out_valid | out_ready;
  // The second entry only fills while the head is stalled, so no word is lost.
  assign skid_valid_nxt = head_free ? 1'b0 : (skid_valid_r | accept);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      skid_valid_r <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      if (head_free) begin
        out_valid <= skid_valid_r | accept;
      end
      skid_valid_r <= skid_valid_nxt;
      in_ready <= ~skid_valid_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (head_free) begin
      out_data <= skid_valid_r ? skid_r : in_data;
    end else if (accept) begin
      skid_r <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/vmx_sink_model.sv ----
// Purpose: Downstream sink for the digital output that stalls at a chosen rate.
// Assumes: Runs on the block clock.
// Notes: Ready changes only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module vmx_sink_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Stall rate in percent and handshake.
  input wire logic [6:0] stall_pct,
  output logic ready
);
  // Random stalls are what push the two-entry buffer into refusing words.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      ready <= ($urandom % 100) >= stall_pct;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/video_mixer_output_control_tb.sv ----
// Purpose: Self-checking bench for the mixer control block.
// Assumes: Latency parameters at their defaults; key table entries 0 and 1 hold zero.
// Notes: Alpha is only 0 or unity so that every mixer result is exact.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module video_mixer_output_control_tb;
  localparam logic [11:0] SEL2 = 12'h489;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs = 1'b0;
  logic wr = 1'b0;
  logic [3:0] ad = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [23:0] pa = 24'h00_0000;
  logic [23:0] pb = 24'h00_0000;
  logic [8:0] al = 9'h000;
  logic [2:0] xs = 3'h0;
  logic [7:0] ka = 8'h00;
  logic [6:0] stall = 7'h00;
  logic pv = 1'b0;
  logic sn = 1'b1;
  logic kw = 1'b0;
  logic ki = 1'b0;
  logic si = 1'b0;
  logic bi = 1'b0;
  logic run = 1'b0;
  logic steady = 1'b0;
  logic ph = 1'b0;
  logic [7:0] rdv, d, mix_r, out_r, conv_r, fr_r, fg_r, fb_r;
  logic [23:0] mo, cd, a_prev, b_prev;
  logic pr, ko, oe, mv, mr, cy, cb, cp, cu;
  logic [2:0] hist[0:15];
  logic [23:0] q[$];
  int miscompares = 0;
  int checks_done = 0;

  vmx_mixer_ctrl i_dut (
    .clk(clk), .rst(rst), .reg_cs(cs), .reg_wr(wr), .reg_addr(ad), .reg_wdata(wd),
    .reg_rdata(rdv), .first_pixel_port(pa), .second_pixel_port(pb), .pixel_valid(pv),
    .pixel_ready(pr), .alpha_in(al), .crosspoint_select(xs), .bypass_strobe_n(sn),
    .key_table_wr(kw), .key_table_addr(ka), .key_table_data(8'h00),
    .key_delay_in(ki), .key_delay_output(ko), .mix_out_data(mo), .mix_out_oe(oe),
    .mix_out_valid(mv), .mix_out_ready(mr), .conv_sync_in(si), .conv_blank_in(bi),
    .conv_data(cd), .conv_sync(cy), .conv_blank(cb), .converter_power_on(cp),
    .conv_setup(cu)
  );
  vmx_sink_model i_sink (.clk(clk), .rst(rst), .stall_pct(stall), .ready(mr));

  initial begin
    forever #4 clk = ~clk;
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    cs <= 1'b1;
    wr <= 1'b1;
    ad <= a;
    wd <= v;
    @(posedge clk);
    cs <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    cs <= 1'b1;
    wr <= 1'b0;
    ad <= a;
    @(posedge clk);
    cs <= 1'b0;
    @(negedge clk);
    v = rdv;
  endtask

  function automatic logic [23:0] exp_pix(input logic [23:0] a, b, input logic [8:0] l,
      input logic [2:0] x, input logic n);
    logic [23:0] src[0:2];
    logic [23:0] v1, v2, r;
    logic [8:0] s;
    logic one;
    src[0] = a;
    src[1] = b;
    src[2] = {fg_r, fb_r, fr_r};
    if (mix_r[4:2] != 3'h7) x = mix_r[4:2];
    if (x > 3'h5) x = 3'h0;
    v1 = src[x[2:1]];
    v2 = src[SEL2[2*x +: 2]];
    one = l[8] && !out_r[5];
    r = one ? v1 : v2;
    if (mix_r[1:0] == 2'h2) r = one ? v1 : 24'h00_0000;
    for (int k = 0; k < 24; k += 8) begin
      s = {1'b0, v1[k +: 8]} + {1'b0, v2[k +: 8]};
      if (mix_r[1:0] == 2'h1 && one) r[k +: 8] = s[8] ? 8'hFF : s[7:0];
    end
    if (!n) r = out_r[4] ? (out_r[3] ? b : a) : v2;
    if (out_r[0]) r = {8'h00, r[23:16], ph ? r[7:0] : r[15:8]};
    return r ^ (out_r[1] ? 24'h00_8080 : 24'h00_0000);
  endfunction

  function automatic logic [7:0] clip(input int x);
    return (x < 0) ? 8'h00 : ((x > 255) ? 8'hFF : 8'(x));
  endfunction

  function automatic logic [23:0] exp_conv();
    logic [23:0] s;
    int y, u, v;
    s = (mix_r[5] ? b_prev : a_prev) ^ (conv_r[4] ? 24'h00_8080 : 24'h00_0000);
    y = int'(s[23:16]);
    u = int'(s[15:8]) - 128;
    v = int'(s[7:0]) - 128;
    if (conv_r[0]) begin
      s = {clip(y - ((88 * u + 183 * v) >>> 8)), clip(y + ((454 * u) >>> 8)),
           clip(y + ((359 * v) >>> 8))};
    end
    return conv_r[3] ? s : 24'h00_0000;
  endfunction
////////////////////////////////////////////////////////////////////////////////
  // Requests are held while refused, so a stalled word never changes under the design.
  always @(posedge clk) begin
    if (!rst) begin
      if (!pv || pr) begin
        pv <= run && ($urandom % 4 != 0);
        pa <= $urandom;
        pb <= $urandom;
        al <= ($urandom % 2) ? 9'h101 : 9'h000;
        xs <= $urandom;
        sn <= ($urandom % 3) != 0;
      end
      {si, bi, ki} <= $urandom;
    end
  end

  always @(posedge clk) begin
    if (!rst) begin
      if (mv && mr) check("mix_out_data", mo, q.size() != 0 ? q.pop_front() : ~mo);
      if (pv && pr) begin
        q.push_back(exp_pix(pa, pb, al, xs, sn));
        ph <= out_r[0] & ~ph;
      end
      if (steady) begin
        check("key_delay_output", 24'(ko), 24'(hist[out_r[7] ? 11 : 13][0]));
        check("conv_sync_blank", 24'({cy, cb}), 24'(hist[conv_r[5] ? 1 : 14][2:1]));
        check("mix_out_oe", 24'(oe), 24'(out_r[2]));
        check("conv_power_setup", 24'({cp, cu}), 24'(conv_r[3:2]));
        if (mix_r[6:5] < 2'h2) check("conv_data", cd, exp_conv());
      end
      for (int k = 15; k > 0; k--) hist[k] <= hist[k-1];
      hist[0] <= {si, bi, ki};
      a_prev <= pa;
      b_prev <= pb;
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h4713));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      reg_read(4'(i), d);
      check("reg_reset", 24'(d), 24'h00_0000);
      reg_write(4'(i), (i == 2) ? 8'hDE : 8'hFF);
      reg_read(4'(i), d);
      check("reg_readback", 24'(d), (i == 2) ? 24'hDE : (i == 6) ? 24'hBF : (i == 7) ? 24'h3D : (i > 2 && i < 6) ? 24'hFF : 24'h00);
    end
    @(posedge clk);
    kw <= 1'b1;
    @(posedge clk);
    ka <= 8'h01;
    @(posedge clk);
    kw <= 1'b0;
    for (int n = 0; n < 48; n++) begin
      @(negedge clk);
      steady = 1'b0;
      // Reserved codes are never written; code 6 is moved to the pin-driven code.
      mix_r = {1'b1, 2'($urandom % 3), 3'($urandom % 7), 2'($urandom % 3)};
      if (mix_r[4:2] == 3'h6) mix_r[4:2] = 3'h7;
      if (mix_r[1:0] == 2'h0) mix_r[7] = 1'($urandom);
      out_r = 8'($urandom) & 8'hBF;
      conv_r = 8'($urandom) & 8'h3D;
      {fr_r, fg_r, fb_r} = 24'($urandom);
      stall <= 7'($urandom % 80);
      reg_write(4'h2, mix_r);
      reg_write(4'h3, fr_r);
      reg_write(4'h4, fg_r);
      reg_write(4'h5, fb_r);
      reg_write(4'h6, out_r);
      reg_write(4'h7, conv_r);
      repeat (20) @(posedge clk);
      @(negedge clk);
      steady = 1'b1;
      run = 1'b1;
      repeat (60) @(posedge clk);
      @(negedge clk);
      run = 1'b0;
      for (int w = 0; w < 200 && (q.size() != 0 || pv); w++) @(posedge clk);
    end
    check("words_left", 24'(q.size()), 24'h00_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
